// ===== shared/adcpp_pkg.sv
// shared constants for the converter result ping-pong and serial clocking block
package adcpp_pkg;
   localparam int unsigned NUM_CH        = 8;     // logical channels per bank
   localparam int unsigned WORD_W        = 16;    // result word width
   localparam int unsigned CH_W          = 3;
   localparam int unsigned BIT_W         = 3;     // bit index inside a byte
   localparam int unsigned LNR_SCANS     = 4;     // scans to refill the noise filters
   localparam int unsigned SCLK_DIV      = 8;     // self clock is master clock / 8
   localparam int unsigned SCLK_HALF     = SCLK_DIV / 2;
   localparam int unsigned DIV_W         = 2;
   localparam logic [CH_W-1:0]  LAST_CH        = 3'h7;
   localparam logic [CH_W-1:0]  FIRST_CH       = 3'h0;
   localparam logic [1:0]       FILL_FULL      = 2'h3;   // LNR_SCANS - 1
   localparam logic [DIV_W-1:0] DIV_LAST       = 2'h3;   // SCLK_HALF - 1
   localparam logic [BIT_W-1:0] BIT_LAST       = 3'h7;
   localparam logic             BANK_A         = 1'b0;
   localparam logic             BANK_B         = 1'b1;
   localparam logic             SCAN_DONE_IDLE = 1'b1;
   localparam logic             SCLK_IDLE      = 1'b1;
endpackage

// ===== verilog/adcpp_core.sv
// result double buffer, conversion restart control and serial read port
`timescale 1ns/1ps
module adcpp_core
(
   input  wire logic                           mclk,
   input  wire logic                           rst,
   input  wire logic                           mode_pin,
   input  wire logic                           three_wire,
   input  wire logic                           msb_first,
   input  wire logic                           byte_msb_first,
   input  wire logic                           sleep_bit,
   input  wire logic                           line_noise_rejection,
   input  wire logic [adcpp_pkg::CH_W-1:0]     active_last,
   input  wire logic                           cal_access,
   input  wire logic                           result_read_req,
   input  wire logic                           result_write_req,
   input  wire logic                           conv_done,
   input  wire logic [adcpp_pkg::WORD_W-1:0]   conv_data,
   input  wire logic                           sclk_in,
   input  wire logic                           sdio_in,
   output logic                                sclk_out,
   output logic                                sclk_oe_n,
   output logic                                sdio_out,
   output logic                                sdio_oe_n,
   output logic                                serial_out_line,
   output logic [7:0]                          rx_byte,
   output logic                                rx_byte_valid,
   output logic                                scan_done_n,
   output logic                                conv_run,
   output logic                                filter_reset,
   output logic                                lnr_clear,
   output logic [adcpp_pkg::CH_W-1:0]          chan_ptr,
   output logic                                read_busy,
   output logic                                write_bank
);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic       sclk_m;
   logic       sclk_s;
   logic       sclk_d;
   logic       sdio_m;
   logic       sdio_s;
   logic       mode_m;
   logic       mode_s;

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         sclk_m <= adcpp_pkg::SCLK_IDLE;
         sclk_s <= adcpp_pkg::SCLK_IDLE;
         sclk_d <= adcpp_pkg::SCLK_IDLE;
         sdio_m <= 1'b0;
         sdio_s <= 1'b0;
         mode_m <= 1'b0;
         mode_s <= 1'b0;
      end
      else
      begin
         sclk_m <= sclk_in;
         sclk_s <= sclk_m;
         sclk_d <= sclk_s;
         sdio_m <= sdio_in;
         sdio_s <= sdio_m;
         mode_m <= mode_pin;
         mode_s <= mode_m;
      end
   end

   // ----------------------------------------------------------------
   // serial clock: self generated or host supplied
   // ----------------------------------------------------------------
   logic [adcpp_pkg::DIV_W-1:0] div_cnt;
   logic                        self_rise;
   logic                        self_fall;
   logic                        ser_rise;
   logic                        ser_fall;
   logic                        div_tick;

   assign div_tick  = mode_s && read_busy && (div_cnt == adcpp_pkg::DIV_LAST);
   assign self_rise = div_tick && !sclk_out;
   assign self_fall = div_tick && sclk_out;
   // edges seen only between stable levels, so a stalled clock makes none
   assign ser_rise  = mode_s ? self_rise : (sclk_s && !sclk_d);
   assign ser_fall  = mode_s ? self_fall : (!sclk_s && sclk_d);

   always_ff @(posedge mclk)
   begin
      if (rst || !read_busy || !mode_s)
         div_cnt <= '0;
      else
         div_cnt <= div_cnt + 1'b1;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         sclk_out  <= adcpp_pkg::SCLK_IDLE;
         sclk_oe_n <= 1'b1;
      end
      else
      begin
         sclk_oe_n <= !mode_s;
         if (!mode_s || !read_busy)
            sclk_out <= adcpp_pkg::SCLK_IDLE;
         else if (div_tick)
            sclk_out <= !sclk_out;
      end
   end

   // ----------------------------------------------------------------
   // conversion sequencing and restart
   // ----------------------------------------------------------------
   logic       halt;
   logic [1:0] fill_cnt;
   logic       last_ch;
   logic       scan_complete;
   logic       take_result;

   assign halt          = sleep_bit || cal_access;
   assign last_ch       = line_noise_rejection ? (chan_ptr == adcpp_pkg::LAST_CH)
                                               : (chan_ptr == active_last);
   assign take_result   = conv_done && !halt && (chan_ptr <= active_last);
   assign scan_complete = conv_done && !halt && last_ch &&
                          (!line_noise_rejection || fill_cnt == adcpp_pkg::FILL_FULL);

   always_ff @(posedge mclk)
   begin
      if (rst || halt)
      begin
         chan_ptr <= adcpp_pkg::FIRST_CH;
         fill_cnt <= '0;
      end
      else if (conv_done)
      begin
         if (last_ch)
         begin
            chan_ptr <= adcpp_pkg::FIRST_CH;
            if (fill_cnt != adcpp_pkg::FILL_FULL)
               fill_cnt <= fill_cnt + 1'b1;
         end
         else
            chan_ptr <= chan_ptr + 1'b1;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         conv_run     <= 1'b0;
         filter_reset <= 1'b1;
         lnr_clear    <= 1'b1;
      end
      else
      begin
         conv_run     <= !halt;
         filter_reset <= halt;
         lnr_clear    <= sleep_bit;
      end
   end

   // ----------------------------------------------------------------
   // result banks and ping-pong control
   // ----------------------------------------------------------------
   logic [adcpp_pkg::WORD_W-1:0] result_mem [0:2*adcpp_pkg::NUM_CH-1];
   logic                         do_swap;
   logic                         read_start;

   // a write request to the result banks blocks a read start in the same cycle
   assign read_start = result_read_req && !read_busy && !result_write_req;
   assign do_swap    = scan_complete && !read_busy;

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         for (int i = 0; i < 2*adcpp_pkg::NUM_CH; i++)
            result_mem[i] <= '0;
      end
      else if (take_result)
         result_mem[{write_bank, chan_ptr}] <= conv_data;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
         write_bank <= adcpp_pkg::BANK_A;
      else if (do_swap)
         write_bank <= !write_bank;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
         scan_done_n <= adcpp_pkg::SCAN_DONE_IDLE;
      else if (do_swap)
         scan_done_n <= 1'b0;
      else if (halt || read_start)
         scan_done_n <= adcpp_pkg::SCAN_DONE_IDLE;
   end

   // ----------------------------------------------------------------
   // serial result burst
   // ----------------------------------------------------------------
   logic [adcpp_pkg::CH_W-1:0]  rd_word;
   logic                        rd_byte;
   logic [adcpp_pkg::BIT_W-1:0] rd_bit;
   logic                        rd_last;
   logic                        rd_bank;
   logic                        byte_sel;
   logic [adcpp_pkg::BIT_W-1:0] bit_sel;
   logic [adcpp_pkg::WORD_W-1:0] rd_word_data;
   logic                        tx_bit;
   logic                        at_end;

   assign rd_bank      = !write_bank;
   assign byte_sel     = byte_msb_first ? !rd_byte : rd_byte;
   assign bit_sel      = msb_first ? (adcpp_pkg::BIT_LAST - rd_bit) : rd_bit;
   assign rd_word_data = result_mem[{rd_bank, rd_word}];
   assign tx_bit       = rd_word_data[{byte_sel, bit_sel}];
   assign at_end       = (rd_word == active_last) && rd_byte && (rd_bit == adcpp_pkg::BIT_LAST);

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         read_busy <= 1'b0;
         rd_word   <= '0;
         rd_byte   <= 1'b0;
         rd_bit    <= '0;
         rd_last   <= 1'b0;
      end
      else if (read_start)
      begin
         read_busy <= 1'b1;
         rd_word   <= '0;
         rd_byte   <= 1'b0;
         rd_bit    <= '0;
         rd_last   <= 1'b0;
      end
      else if (read_busy)
      begin
         if (ser_fall)
            rd_last <= at_end;
         if (ser_rise)
         begin
            // host has taken the bit driven on the previous falling edge
            if (rd_last)
               read_busy <= 1'b0;
            else
            begin
               rd_bit <= rd_bit + 1'b1;
               if (rd_bit == adcpp_pkg::BIT_LAST)
               begin
                  rd_byte <= !rd_byte;
                  if (rd_byte)
                     rd_word <= rd_word + 1'b1;
               end
            end
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         sdio_out        <= 1'b0;
         sdio_oe_n       <= 1'b1;
         serial_out_line <= 1'b0;
      end
      else
      begin
         if (ser_fall && read_busy)
         begin
            sdio_out        <= three_wire ? 1'b0 : tx_bit;
            serial_out_line <= three_wire ? tx_bit : 1'b0;
         end
         // two-wire read turns the data line round for the burst
         sdio_oe_n <= !(read_busy && !three_wire);
      end
   end

   // ----------------------------------------------------------------
   // incoming bits, sampled on rising serial clock
   // ----------------------------------------------------------------
   logic [adcpp_pkg::BIT_W-1:0] rx_cnt;

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         rx_byte       <= '0;
         rx_cnt        <= '0;
         rx_byte_valid <= 1'b0;
      end
      else
      begin
         rx_byte_valid <= 1'b0;
         // no capture while the data line is turned round for output
         if (ser_rise && !(read_busy && !three_wire))
         begin
            rx_byte <= msb_first ? {rx_byte[6:0], sdio_s} : {sdio_s, rx_byte[7:1]};
            rx_cnt  <= rx_cnt + 1'b1;
            if (rx_cnt == adcpp_pkg::BIT_LAST)
               rx_byte_valid <= 1'b1;
         end
      end
   end

endmodule

// ===== bench/adcpp_core_assertions.sv
// concurrent checks on the result double buffer, restart control and self clock
`timescale 1ns/1ps
module adcpp_core_assertions
(
   input wire logic                        mclk,
   input wire logic                        rst,
   input wire logic                        sleep_bit,
   input wire logic                        cal_access,
   input wire logic                        line_noise_rejection,
   input wire logic [adcpp_pkg::CH_W-1:0]  active_last,
   input wire logic                        conv_done,
   input wire logic                        result_read_req,
   input wire logic                        result_write_req,
   input wire logic                        sclk_out,
   input wire logic                        scan_done_n,
   input wire logic                        conv_run,
   input wire logic [adcpp_pkg::CH_W-1:0]  chan_ptr,
   input wire logic                        read_busy,
   input wire logic                        write_bank
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   property p_swap;
      !line_noise_rejection && conv_done && !sleep_bit && !cal_access && chan_ptr == active_last && !read_busy
      |=> write_bank != $past(write_bank) && !scan_done_n;
   endproperty
   a_swap: assert property (p_swap) else $error("banks did not swap at scan end");
   property p_hold;
      read_busy |=> $stable(write_bank);
   endproperty
   a_hold: assert property (p_hold) else $error("bank swapped during a read");
   property p_halt;
      sleep_bit || cal_access |=> scan_done_n && !conv_run && chan_ptr == adcpp_pkg::FIRST_CH;
   endproperty
   a_halt: assert property (p_halt) else $error("halt did not stop and rewind");
   property p_sleep_keep;
      sleep_bit |=> $stable(write_bank);
   endproperty
   a_sleep_keep: assert property (p_sleep_keep) else $error("sleep changed the banks");
   property p_wake;
      $fell(sleep_bit) && !cal_access |=> conv_run;
   endproperty
   a_wake: assert property (p_wake) else $error("conversion did not restart");
   property p_read_start;
      result_read_req && !read_busy && !result_write_req && !conv_done |=> read_busy && scan_done_n;
   endproperty
   a_read_start: assert property (p_read_start) else $error("read start not taken");
   property p_wr_refused;
      result_write_req && !read_busy |=> !read_busy;
   endproperty
   a_wr_refused: assert property (p_wr_refused) else $error("result write started a burst");
   property p_sclk_rate;
      $changed(sclk_out) |=> $stable(sclk_out)[*3];
   endproperty
   a_sclk_rate: assert property (p_sclk_rate) else $error("self clock half period short");
endmodule
bind adcpp_core adcpp_core_assertions adcpp_core_assertions_inst (.mclk, .rst, .sleep_bit, .cal_access,
   .line_noise_rejection, .active_last, .conv_done, .result_read_req, .result_write_req, .sclk_out,
   .scan_done_n, .conv_run, .chan_ptr, .read_busy, .write_bank);

// ===== bench/adcpp_host_model.sv
// host serial port model: clocks bursts, writes bytes, collects read bits
`timescale 1ns/1ps
module adcpp_host_model
(
   input  wire logic mode_pin,
   input  wire logic three_wire,
   input  wire logic sclk_out,
   input  wire logic sdio_out,
   input  wire logic sdio_oe_n,
   input  wire logic serial_out_line,
   output logic      sclk_in,
   output logic      sdio_in
);
   logic host_bit = 1'b1;
   logic bits[$];
   wire  data_line = three_wire ? serial_out_line : sdio_out;
   initial sclk_in = adcpp_pkg::SCLK_IDLE;
   assign sdio_in = sdio_oe_n ? host_bit : sdio_out;
   always @(posedge sclk_out)
   begin
      if (mode_pin)
      begin
         bits.push_back(data_line);
      end
   end
   // clock stands high between frames; read bit taken late in the high phase
   // called on a falling master edge, so every change stays off the sampling edge
   task automatic clock_bits(input int n, input logic [7:0] wr);
      for (int i = 0; i < n; i++)
      begin
         sclk_in = 1'b0;
         #20 host_bit = wr[7 - (i % 8)];
         #60 sclk_in = 1'b1;
         #60 bits.push_back(data_line);
         #20;
      end
      host_bit = ~host_bit;
   endtask
endmodule

// ===== bench/testbench.sv
// self-checking bench for the result double buffer and serial port
`timescale 1ns/1ps
module testbench;
   logic mclk = 1'b0, rst = 1'b1, mode_pin = 1'b0, three_wire = 1'b1, msb_first = 1'b1;
   logic byte_msb_first = 1'b1, sleep_bit = 1'b0, line_noise_rejection = 1'b0, cal_access = 1'b0;
   logic result_read_req = 1'b0, result_write_req = 1'b0, conv_done = 1'b0;
   logic [adcpp_pkg::CH_W-1:0] active_last = 3'h3;
   logic [adcpp_pkg::WORD_W-1:0] conv_data = 16'h0000;
   logic sclk_in, sdio_in, sclk_out, sclk_oe_n, sdio_out, sdio_oe_n, serial_out_line, scan_done_n;
   logic conv_run, filter_reset, lnr_clear, read_busy, write_bank;
   logic [adcpp_pkg::CH_W-1:0] chan_ptr;
   logic [7:0] rx_byte;
   logic rx_byte_valid;
   int rx_valid_cnt = 0;
   int err_total = 0, total_checks = 0;
   adcpp_core adcpp_core_inst (.mclk, .rst, .mode_pin, .three_wire, .msb_first, .byte_msb_first,
      .sleep_bit, .line_noise_rejection, .active_last, .cal_access, .result_read_req, .result_write_req,
      .conv_done, .conv_data, .sclk_in, .sdio_in, .sclk_out, .sclk_oe_n, .sdio_out, .sdio_oe_n,
      .serial_out_line, .rx_byte, .rx_byte_valid, .scan_done_n, .conv_run, .filter_reset, .lnr_clear,
      .chan_ptr, .read_busy, .write_bank);
   adcpp_host_model adcpp_host_model_inst (.mode_pin, .three_wire, .sclk_out, .sdio_out, .sdio_oe_n,
      .serial_out_line, .sclk_in, .sdio_in);
   initial
   begin
      forever #10 mclk = ~mclk;
   end
   // counts byte-complete pulses; each stands one cycle
   always @(posedge mclk)
      if (rx_byte_valid === 1'b1)
         rx_valid_cnt++;
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask
   task automatic conv_scan(input int n, input logic [3:0] tg);
      for (int ch = 0; ch < n; ch++)
      begin
         @(posedge mclk);
         conv_done <= 1'b1;
         conv_data <= {4'hA, tg, 5'h00, ch[2:0]};
         @(posedge mclk);
         conv_done <= 1'b0;
      end
      @(negedge mclk);
   endtask
   task automatic start_read();
      adcpp_host_model_inst.bits.delete();
      @(posedge mclk);
      result_read_req <= 1'b1;
      @(posedge mclk);
      result_read_req <= 1'b0;
      @(negedge mclk);
      check(read_busy, 1'b1);
      check(scan_done_n, 1'b1);
   endtask
   // four words of the given scan, in the given bit and byte order
   task automatic cmp_bits(input logic [3:0] tg, input logic msb, input logic bh);
      logic [15:0] w;
      logic [7:0] by;
      check(16'(adcpp_host_model_inst.bits.size()), 16'h0040);
      for (int i = 0; i < 64; i++)
      begin
         w = {4'hA, tg, 6'h00, i[5:4]};
         by = ((i[3] == 1'b0) == bh) ? w[15:8] : w[7:0];
         check(adcpp_host_model_inst.bits[i], msb ? by[3'h7 - i[2:0]] : by[i[2:0]]);
      end
   endtask
   task automatic ext_finish(input int n);
      adcpp_host_model_inst.clock_bits(n, 8'h00);
      tick(8);
      check(read_busy, 1'b0);
   endtask
   task automatic t_basic();
      check(write_bank, adcpp_pkg::BANK_A);
      check(scan_done_n, 1'b1);
      adcpp_host_model_inst.clock_bits(8, 8'hC5);
      tick(6);
      check(rx_byte, 8'hC5);
      check(16'(rx_valid_cnt), 16'h0001);
      start_read();
      ext_finish(64);
      check(16'(adcpp_host_model_inst.bits.size()), 16'h0040);
      for (int i = 0; i < 64; i++)
         check(adcpp_host_model_inst.bits[i], 16'h0000);
      conv_scan(4, 4'h1);
      check(scan_done_n, 1'b0);
      check(write_bank, adcpp_pkg::BANK_B);
      @(posedge mclk);
      result_read_req <= 1'b1;
      result_write_req <= 1'b1;
      @(posedge mclk);
      result_read_req <= 1'b0;
      result_write_req <= 1'b0;
      tick(1);
      check(read_busy, 1'b0);
      start_read();
      ext_finish(64);
      cmp_bits(4'h1, 1'b1, 1'b1);
   endtask
   task automatic t_overrun();
      conv_scan(4, 4'h2);
      check(write_bank, adcpp_pkg::BANK_A);
      conv_scan(4, 4'h3);
      check(scan_done_n, 1'b0);
      check(write_bank, adcpp_pkg::BANK_B);
      start_read();
      adcpp_host_model_inst.clock_bits(16, 8'h00);
      conv_scan(4, 4'h4);
      check(write_bank, adcpp_pkg::BANK_B);
      ext_finish(48);
      cmp_bits(4'h3, 1'b1, 1'b1);
      conv_scan(4, 4'h5);
      check(write_bank, adcpp_pkg::BANK_A);
   endtask
   task automatic t_self();
      @(posedge mclk);
      mode_pin <= 1'b1;
      three_wire <= 1'b0;
      msb_first <= 1'b0;
      byte_msb_first <= 1'b0;
      tick(6);
      check(sclk_oe_n, 1'b0);
      start_read();
      tick(2);
      check(sdio_oe_n, 1'b0);
      for (int i = 0; i < 4000 && read_busy !== 1'b0; i++) @(negedge mclk);
      check(read_busy, 1'b0);
      tick(2);
      cmp_bits(4'h5, 1'b0, 1'b0);
   endtask
   task automatic t_sleep_cal();
      conv_scan(4, 4'hA);
      @(posedge mclk);
      sleep_bit <= 1'b1;
      line_noise_rejection <= 1'b1;
      tick(2);
      check(scan_done_n, 1'b1);
      check(chan_ptr, adcpp_pkg::FIRST_CH);
      check(lnr_clear, 1'b1);
      check(write_bank, adcpp_pkg::BANK_B);
      @(posedge mclk);
      sleep_bit <= 1'b0;
      tick(2);
      check(conv_run, 1'b1);
      for (int s = 0; s < 3; s++) conv_scan(8, 4'h6);
      check(scan_done_n, 1'b1);
      conv_scan(8, 4'h7);
      check(scan_done_n, 1'b0);
      @(posedge mclk);
      cal_access <= 1'b1;
      tick(3);
      check(scan_done_n, 1'b1);
      check(filter_reset, 1'b1);
      check(chan_ptr, adcpp_pkg::FIRST_CH);
      @(posedge mclk);
      cal_access <= 1'b0;
      tick(2);
      check(conv_run, 1'b1);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
      begin
         $display("Regression OK");
      end
      else
      begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial
   begin
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      tick(3);
      t_basic();
      t_overrun();
      t_self();
      t_sleep_cal();
      results();
   end
   initial
   begin
      #1000000;
      err_total++;
      results();
   end
endmodule
